// ---- rtl/bpe_defs.vh ----
// Constants for the bridge parity error reporting block
//
// Summary of operation
// - Primary parity error only as primary write target or read initiator.
// - Primary parity error needs primary parity response bit set.
// - Primary bus data parity error on up read, down writes asserts it.
// - Secondary pin at down delayed write completion reported on primary.
// - Secondary parity error only as secondary write target or read master.
// - Secondary parity error needs secondary parity response bit set.
// - Secondary data parity error on down read, up writes asserts it.
// - Primary pin at up delayed write completion reported on secondary.
// - Target side parity pin on posted write raises primary system error.
// - No system error for posted write errors seen as its target.
// - Posted write system error needs both parity response bits set.
// - System error for parity needs system error enable bit.
// - Never system error for read or delayed write parity errors.
// - Delayed write forwarding only when error absent on initiator bus.
// - Secondary master data parity bit set while mastering with response.
// - Each system error assertion also sets signaled system error status.
`ifndef BPE_DEFS_VH
`define BPE_DEFS_VH
// Register byte offsets
`define BPE_REG_CTRL 8'h00
`define BPE_REG_STATUS 8'h04
`define BPE_REG_MASK 8'h08
`define BPE_REG_STATE 8'h0C
// Control fields
`define BPE_CTRL_PRI_RESP 0
`define BPE_CTRL_SERR_EN 1
`define BPE_CTRL_SEC_RESP 2
`define BPE_CTRL_RESET 3'h0
// Status and mask fields
`define BPE_ST_SIG_SERR 0
`define BPE_ST_SEC_MDP 1
`define BPE_ST_PRI_PERR 2
`define BPE_ST_SEC_PERR 3
`define BPE_ST_W 4
`define BPE_ST_RESET 4'h0
// Transaction type codes
`define BPE_TY_READ 2'h0
`define BPE_TY_POSTED 2'h1
`define BPE_TY_DELAYED 2'h2
// Direction codes
`define BPE_DIR_DOWN 1'b0
`define BPE_DIR_UP 1'b1
// AXI responses
`define BPE_RESP_OKAY 2'h0
`define BPE_RESP_SLVERR 2'h2
`endif

// ---- rtl/bpe_line_drv.v ----
// Drives one active-low PCI error line on link clock edges
`timescale 1ns/100ps
module bpe_line_drv #(
    parameter HOLD_HIGH = 1
)(
    clk, // Core clock
    rst_n, // Asynchronous reset, active low
    ce, // Clock enable
    linkEdge, // Rising edge of the link clock seen
    req, // Request to assert, one cycle pulse
    lineOut, // Line level when driven
    lineOe_n, // Output enable, low while driving
    busy // Sequence in progress
);
    input wire clk;
    input wire rst_n;
    input wire ce;
    input wire linkEdge;
    input wire req;
    output wire lineOut;
    output wire lineOe_n;
    output wire busy;

    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_LOW = 2'h2;
    localparam ST_HIGH = 2'h3;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg pend_reg;

    // Next state; idle leaves on a request, the other states step once per link edge
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (req || pend_reg) state_next = ST_WAIT;
            ST_WAIT: if (linkEdge) state_next = ST_LOW;
            ST_LOW: if (linkEdge)
                state_next = (HOLD_HIGH != 0) ? ST_HIGH : ST_IDLE;
            ST_HIGH: if (linkEdge) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // State and pending request; a request outside idle is held, idle clears it
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            pend_reg <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            if (req && state_reg != ST_IDLE)
                pend_reg <= 1'b1;
            else if (state_reg == ST_IDLE)
                pend_reg <= 1'b0;
        end
    end

    // Low for one link clock, then driven high if sustained tri-state
    assign lineOut = (state_reg != ST_LOW);
    assign lineOe_n = !(state_reg == ST_LOW || state_reg == ST_HIGH);
    assign busy = (state_reg != ST_IDLE) || pend_reg;
endmodule

// ---- rtl/bpe_report.v ----
// Parity and system error reporting for a two-port PCI bridge
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "bpe_defs.vh"
module bpe_report (
    core_clk, // Core clock, 250 MHz
    rst_n, // Asynchronous reset, active low
    ce, // Clock enable, freezes all state when low
    s_axi_awaddr, // Write address
    s_axi_awvalid, // Write address valid
    s_axi_awready, // Write address ready
    s_axi_wdata, // Write data
    s_axi_wstrb, // Write byte strobes
    s_axi_wvalid, // Write data valid
    s_axi_wready, // Write data ready
    s_axi_bresp, // Write response
    s_axi_bvalid, // Write response valid
    s_axi_bready, // Write response ready
    s_axi_araddr, // Read address
    s_axi_arvalid, // Read address valid
    s_axi_arready, // Read address ready
    s_axi_rdata, // Read data
    s_axi_rresp, // Read response
    s_axi_rvalid, // Read data valid
    s_axi_rready, // Read data ready
    irq, // Interrupt, high level
    priPciClk, // Primary PCI clock pin
    secPciClk, // Secondary PCI clock pin
    priPhase, // Bridge data phase on primary bus
    priType, // Primary transaction type
    priDir, // Primary transaction direction
    priParErr, // Data parity error computed on primary
    priInitErr, // Error already seen on initiator bus
    secPhase, // Bridge data phase on secondary bus
    secType, // Secondary transaction type
    secDir, // Secondary transaction direction
    secParErr, // Data parity error computed on secondary
    secInitErr, // Error already seen on initiator bus
    secMaster, // Bridge masters secondary bus
    primary_parity_error_line_in, // Primary parity error pin level
    primary_parity_error_line_out, // Primary parity error drive level
    primary_parity_error_line_oe_n, // Drive enable, low while driving
    secondary_parity_error_line_in, // Secondary parity error pin level
    secondary_parity_error_line_out, // Secondary parity error drive level
    secondary_parity_error_line_oe_n, // Drive enable, low while driving
    primary_system_error_line_out, // System error drive level
    primary_system_error_line_oe_n // Drive enable, low while driving
);
    input wire core_clk;
    input wire rst_n;
    input wire ce;
    input wire [7:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output wire s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output wire s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [7:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output wire s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;
    output wire irq;
    input wire priPciClk;
    input wire secPciClk;
    input wire priPhase;
    input wire [1:0] priType;
    input wire priDir;
    input wire priParErr;
    input wire priInitErr;
    input wire secPhase;
    input wire [1:0] secType;
    input wire secDir;
    input wire secParErr;
    input wire secInitErr;
    input wire secMaster;
    input wire primary_parity_error_line_in;
    output wire primary_parity_error_line_out;
    output wire primary_parity_error_line_oe_n;
    input wire secondary_parity_error_line_in;
    output wire secondary_parity_error_line_out;
    output wire secondary_parity_error_line_oe_n;
    output wire primary_system_error_line_out;
    output wire primary_system_error_line_oe_n;

    // True when the bridge may report on this bus: write target or
    // read initiator. Primary: up read, down writes; secondary mirrored.
    function roleOk;
        input [1:0] ty;
        input dir;
        input onSec;
        begin
            if (ty == `BPE_TY_READ)
                roleOk = (dir == (onSec ? `BPE_DIR_DOWN : `BPE_DIR_UP));
            else
                roleOk = (dir == (onSec ? `BPE_DIR_UP : `BPE_DIR_DOWN));
        end
    endfunction

    // Clock and pin synchronisers plus link edge history
    reg [3:0] syncA_reg;
    reg [3:0] syncB_reg;
    reg priClkOld_reg;
    reg secClkOld_reg;
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA_reg <= 4'hF;
            syncB_reg <= 4'hF;
            priClkOld_reg <= 1'b1;
            secClkOld_reg <= 1'b1;
        end
        else if (ce)
        begin
            syncA_reg <= {priPciClk, secPciClk,
                primary_parity_error_line_in,
                secondary_parity_error_line_in};
            syncB_reg <= syncA_reg;
            priClkOld_reg <= syncB_reg[3];
            secClkOld_reg <= syncB_reg[2];
        end
    end

    wire priEdge = syncB_reg[3] && !priClkOld_reg;
    wire secEdge = syncB_reg[2] && !secClkOld_reg;
    wire priPerrSeen = priEdge && !syncB_reg[1];
    wire secPerrSeen = secEdge && !syncB_reg[0];

    // Register file
    reg [2:0] ctrl_reg;
    reg [`BPE_ST_W-1:0] status_reg;
    reg [`BPE_ST_W-1:0] mask_reg;
    wire priResp = ctrl_reg[`BPE_CTRL_PRI_RESP];
    wire secResp = ctrl_reg[`BPE_CTRL_SEC_RESP];
    wire serrEn = ctrl_reg[`BPE_CTRL_SERR_EN];

    // Primary line: own detection or forwarded secondary pin
    wire priOwnErr = priPhase && priParErr
        && roleOk(priType, priDir, 1'b0);
    wire secDwDown = secPhase && secType == `BPE_TY_DELAYED
        && secDir == `BPE_DIR_DOWN;
    wire fwdToPri = secPerrSeen && secDwDown && secResp
        && !secInitErr;
    wire priPerrReq = priResp && (priOwnErr || fwdToPri);

    // Secondary line: own detection or forwarded primary pin
    wire secOwnErr = secPhase && secParErr
        && roleOk(secType, secDir, 1'b1);
    wire priDwUp = priPhase && priType == `BPE_TY_DELAYED
        && priDir == `BPE_DIR_UP;
    wire fwdToSec = priPerrSeen && priDwUp && priResp
        && !priInitErr;
    wire secPerrReq = secResp && (secOwnErr || fwdToSec);

    // System error only for target-side pin on posted writes
    wire pwDown = secPhase && secType == `BPE_TY_POSTED
        && secDir == `BPE_DIR_DOWN && secPerrSeen
        && !secInitErr;
    wire pwUp = priPhase && priType == `BPE_TY_POSTED
        && priDir == `BPE_DIR_UP && priPerrSeen
        && !priInitErr;
    wire serrReq = (pwDown || pwUp) && priResp && secResp
        && serrEn;

    // Master data parity detected on the secondary bus
    wire secMdp = secMaster && secResp && secPhase
        && (secPerrSeen || secParErr);

    // Link line drivers, each steps on its own bus clock
    wire priBusy;
    wire secBusy;
    wire serrBusy;
    bpe_line_drv #(.HOLD_HIGH(1)) uPriPerr (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .linkEdge(priEdge),
        .req(priPerrReq),
        .lineOut(primary_parity_error_line_out),
        .lineOe_n(primary_parity_error_line_oe_n),
        .busy(priBusy)
    );
    bpe_line_drv #(.HOLD_HIGH(1)) uSecPerr (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .linkEdge(secEdge),
        .req(secPerrReq),
        .lineOut(secondary_parity_error_line_out),
        .lineOe_n(secondary_parity_error_line_oe_n),
        .busy(secBusy)
    );
    bpe_line_drv #(.HOLD_HIGH(0)) uSerr (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .linkEdge(priEdge),
        .req(serrReq),
        .lineOut(primary_system_error_line_out),
        .lineOe_n(primary_system_error_line_oe_n),
        .busy(serrBusy)
    );

    // Write channel holding stations, either order accepted
    reg awHeld_reg;
    reg wHeld_reg;
    reg [7:0] awAddr_reg;
    reg [31:0] wData_reg;
    reg [3:0] wStrb_reg;
    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    wire doRead = s_axi_arvalid && s_axi_arready;

    // Event vector and write-one-to-clear mask
    wire [`BPE_ST_W-1:0] evt;
    assign evt[`BPE_ST_SIG_SERR] = serrReq;
    assign evt[`BPE_ST_SEC_MDP] = secMdp;
    assign evt[`BPE_ST_PRI_PERR] = priPerrReq;
    assign evt[`BPE_ST_SEC_PERR] = secPerrReq;
    wire stSel = doWrite && awAddr_reg == `BPE_REG_STATUS && wStrb_reg[0];
    wire [`BPE_ST_W-1:0] w1c = stSel ? wData_reg[`BPE_ST_W-1:0]
        : {`BPE_ST_W{1'b0}};

    // Bus write side and control registers
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BPE_RESP_OKAY;
            ctrl_reg <= `BPE_CTRL_RESET;
            mask_reg <= `BPE_ST_RESET;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `BPE_RESP_OKAY;
                case (awAddr_reg)
                    `BPE_REG_CTRL:
                        if (wStrb_reg[0]) ctrl_reg <= wData_reg[2:0];
                    `BPE_REG_MASK:
                        if (wStrb_reg[0])
                            mask_reg <= wData_reg[`BPE_ST_W-1:0];
                    `BPE_REG_STATUS: ;
                    `BPE_REG_STATE: ;
                    default: s_axi_bresp <= `BPE_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Sticky status, a new event wins over a clear
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            status_reg <= `BPE_ST_RESET;
        else if (ce)
            status_reg <= (status_reg & ~w1c) | evt;
    end

    // Read side
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BPE_RESP_OKAY;
        end
        else if (ce)
        begin
            if (doRead)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `BPE_RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                case ({s_axi_araddr[7:2], 2'b00})
                    `BPE_REG_CTRL: s_axi_rdata[2:0] <= ctrl_reg;
                    `BPE_REG_STATUS:
                        s_axi_rdata[`BPE_ST_W-1:0] <= status_reg;
                    `BPE_REG_MASK:
                        s_axi_rdata[`BPE_ST_W-1:0] <= mask_reg;
                    `BPE_REG_STATE:
                        s_axi_rdata[2:0] <= {serrBusy, secBusy, priBusy};
                    default: s_axi_rresp <= `BPE_RESP_SLVERR;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(status_reg & mask_reg);
endmodule

// ---- sim/bpe_pci_partner.sv ----
// PCI far side: bus clocks and parity error pins
`timescale 1ns/100ps
module bpe_pci_partner (
    priClk, // Primary clock
    secClk, // Secondary clock
    priOut, // Bridge level
    priOeN, // Bridge enable
    secOut, // Bridge level
    secOeN, // Bridge enable
    priPin, // Resolved pin
    secPin // Resolved pin
);
    output reg priClk;
    output reg secClk;
    input wire priOut;
    input wire priOeN;
    input wire secOut;
    input wire secOeN;
    output wire priPin;
    output wire secPin;
    reg priLow;
    reg secLow;
    // Pull-ups: pin low only where someone drives low
    assign priPin = !(priLow || (!priOeN && !priOut));
    assign secPin = !(secLow || (!secOeN && !secOut));
    // Free clocks of unrelated phase
    initial
    begin
        priClk = 1'b0;
        secClk = 1'b0;
        priLow = 1'b0;
        secLow = 1'b0;
    end
    always #40 priClk = ~priClk;
    initial #13 forever #40 secClk = ~secClk;
    // Error pin low across one rising clock edge
    task flagError(input reg onSec);
    begin
        if (onSec)
        begin
            @(negedge secClk) secLow <= 1'b1;
            @(negedge secClk) secLow <= 1'b0;
        end
        else
        begin
            @(negedge priClk) priLow <= 1'b1;
            @(negedge priClk) priLow <= 1'b0;
        end
    end
    endtask
endmodule

// ---- sim/bpe_report_properties.sv ----
// Checker of the error lines and bus answers
`timescale 1ns/100ps
module bpe_report_properties (
    core_clk, // Clock
    rst_n, // Reset
    s_axi_bvalid, // Write answer
    s_axi_bready, // Write taken
    s_axi_arvalid, // Read request
    s_axi_arready, // Read ready
    s_axi_rvalid, // Read answer
    primary_parity_error_line_out, // Level
    primary_parity_error_line_oe_n, // Enable
    primary_system_error_line_out, // Level
    primary_system_error_line_oe_n // Enable
);
    input wire core_clk;
    input wire rst_n;
    input wire s_axi_bvalid;
    input wire s_axi_bready;
    input wire s_axi_arvalid;
    input wire s_axi_arready;
    input wire s_axi_rvalid;
    input wire primary_parity_error_line_out;
    input wire primary_parity_error_line_oe_n;
    input wire primary_system_error_line_out;
    input wire primary_system_error_line_oe_n;
    reg [5:0] priLow_reg;
    reg [5:0] errLow_reg;
    // Length of the current low drive
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            priLow_reg <= 6'h00;
            errLow_reg <= 6'h00;
        end
        else
        begin
            priLow_reg <= primary_parity_error_line_out ? 6'h00 :
                priLow_reg + 6'h01;
            errLow_reg <= primary_system_error_line_oe_n ? 6'h00 :
                errLow_reg + 6'h01;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence priDrivenLow;
        !primary_parity_error_line_out && !primary_parity_error_line_oe_n;
    endsequence
    sequence priHeldLow;
        priDrivenLow [*8];
    endsequence
    chk_pri_drive_low: assert property (
        !primary_parity_error_line_out |-> priDrivenLow)
        else $error("parity line low while released");
    chk_pri_start_low: assert property (
        $fell(primary_parity_error_line_oe_n) |-> priHeldLow)
        else $error("parity line drive not low");
    chk_pri_high_release: assert property (
        $rose(primary_parity_error_line_oe_n)
        |-> $past(primary_parity_error_line_out))
        else $error("parity line released while low");
    chk_pri_low_width: assert property (
        $rose(primary_parity_error_line_out) |-> priLow_reg inside {[19:21]})
        else $error("parity line low width wrong");
    chk_serr_open_drain: assert property (
        !primary_system_error_line_oe_n |-> !primary_system_error_line_out)
        else $error("system error line driven high");
    chk_serr_low_width: assert property (
        $rose(primary_system_error_line_oe_n) |-> errLow_reg inside {[19:21]})
        else $error("system error low width wrong");
    chk_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_r_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind bpe_report bpe_report_properties chk_u (
    .core_clk, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .primary_parity_error_line_out,
    .primary_parity_error_line_oe_n, .primary_system_error_line_out,
    .primary_system_error_line_oe_n
);

// ---- sim/bridge_parity_error_report_test.sv ----
// Self-checking bench of the bridge error reporting block
`timescale 1ns/100ps
`include "bpe_defs.vh"
`define BPE_CHK(nm, ex, got) \
    begin \
        compares = compares + 1; \
        if ((got) !== (ex)) \
        begin \
            badCount = badCount + 1; \
            $display("[ERR] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module bridge_parity_error_report_test;
    reg core_clk, rst_n, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready;
    reg [7:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg priPhase, priDir, priParErr, priInitErr, secMaster;
    reg secPhase, secDir, secParErr, secInitErr;
    reg [1:0] priType, secType;
    wire priPciClk, secPciClk;
    wire primary_parity_error_line_in, secondary_parity_error_line_in;
    wire primary_parity_error_line_out, primary_parity_error_line_oe_n;
    wire secondary_parity_error_line_out, secondary_parity_error_line_oe_n;
    wire primary_system_error_line_out, primary_system_error_line_oe_n;
    integer badCount, compares, seed, pCnt, sCnt, eCnt, k;
    reg [31:0] r;
    reg [3:0] e;
    reg [33:0] want;
    reg [33:0] expR[$];
    reg [1:0] expB[$];
    bpe_report dut_u (
        .core_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .priPciClk,
        .secPciClk, .priPhase, .priType, .priDir, .priParErr, .priInitErr,
        .secPhase, .secType, .secDir, .secParErr, .secInitErr, .secMaster,
        .primary_parity_error_line_in, .primary_parity_error_line_out,
        .primary_parity_error_line_oe_n, .secondary_parity_error_line_in,
        .secondary_parity_error_line_out, .secondary_parity_error_line_oe_n,
        .primary_system_error_line_out, .primary_system_error_line_oe_n
    );
    bpe_pci_partner partner_u (
        .priClk(priPciClk), .secClk(secPciClk),
        .priOut(primary_parity_error_line_out),
        .priOeN(primary_parity_error_line_oe_n),
        .secOut(secondary_parity_error_line_out),
        .secOeN(secondary_parity_error_line_oe_n),
        .priPin(primary_parity_error_line_in),
        .secPin(secondary_parity_error_line_in)
    );
    always #2 core_clk = ~core_clk;
    // Count drive starts per line
    always @(posedge core_clk)
    begin
        if ($fell(primary_parity_error_line_oe_n))
            pCnt = pCnt + 1;
        if ($fell(secondary_parity_error_line_oe_n)
            && !secondary_parity_error_line_out)
            sCnt = sCnt + 1;
        if ($fell(primary_system_error_line_oe_n))
            eCnt = eCnt + 1;
    end
    // Compare each bus answer with the oldest note
    always @(posedge core_clk)
    begin
        if (s_axi_bvalid && s_axi_bready)
        begin
            want = {32'h0, expB.pop_front()};
            `BPE_CHK("bresp", want[1:0], s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            want = expR.pop_front();
            `BPE_CHK("rdata", want, {s_axi_rresp, s_axi_rdata})
        end
    end
    task summarize;
    begin
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task hang;
    begin
        badCount = badCount + 1;
        $display("[ERR] answer expected 1 seen 0");
        summarize;
    end
    endtask
    task axiWr(input [7:0] a, input [31:0] d, input [1:0] x);
        integer n;
    begin
        expB.push_back(x);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n = n + 1)
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bready <= 1'b0;
                n = 99;
            end
        end
        if (n < 100)
            hang;
    end
    endtask
    task axiRd(input [7:0] a, input [33:0] x);
        integer n;
    begin
        expR.push_back(x);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n = n + 1)
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rready <= 1'b0;
                n = 99;
            end
        end
        if (n < 100)
            hang;
    end
    endtask
    // Status expected after an error on one bus
    function [3:0] expStat(input s, input [1:0] t, input d, input p,
        input [2:0] c, input i, input m);
    begin
        expStat[1] = s && m && c[2];
        if (!p)
        begin
            expStat[2] = !s && c[0]
                && (t == `BPE_TY_READ) == d;
            expStat[3] = s && c[2]
                && (t == `BPE_TY_READ) != d;
            expStat[0] = 1'b0;
        end
        else
        begin
            expStat[2] = s && t == `BPE_TY_DELAYED && !d
                && c[0] && c[2] && !i;
            expStat[3] = !s && t == `BPE_TY_DELAYED && d
                && c[0] && c[2] && !i;
            expStat[0] = t == `BPE_TY_POSTED && s != d
                && c == 3'h7 && !i;
        end
    end
    endfunction
    task runCase(input s, input [1:0] t, input d, input p, input [2:0] c,
        input i, input m, input [3:0] mk);
    begin
        e = expStat(s, t, d, p, c, i, m);
        axiWr(`BPE_REG_CTRL, {29'h0, c}, `BPE_RESP_OKAY);
        axiWr(`BPE_REG_MASK, {28'h0, mk}, `BPE_RESP_OKAY);
        pCnt = 0;
        sCnt = 0;
        eCnt = 0;
        priPhase <= !s;
        secPhase <= s;
        priType <= t;
        secType <= t;
        priDir <= d;
        secDir <= d;
        priParErr <= !s && !p;
        secParErr <= s && !p;
        priInitErr <= i;
        secInitErr <= i;
        secMaster <= m;
        if (p)
            partner_u.flagError(s);
        @(posedge core_clk);
        priPhase <= 1'b0;
        secPhase <= 1'b0;
        priParErr <= 1'b0;
        secParErr <= 1'b0;
        repeat (200) @(posedge core_clk);
        `BPE_CHK("priLine", {31'h0, e[2]}, pCnt)
        `BPE_CHK("secLine", {31'h0, e[3]}, sCnt)
        `BPE_CHK("errLine", {31'h0, e[0]}, eCnt)
        `BPE_CHK("irq", |(e & mk), irq)
        axiRd(`BPE_REG_STATUS, {30'h0, e});
        axiWr(`BPE_REG_STATUS, 32'h0000000F, `BPE_RESP_OKAY);
        @(posedge core_clk);
        `BPE_CHK("irqClear", 1'b0, irq)
    end
    endtask
    // Reset, register checks, then every type, direction and bus
    initial
    begin
        {core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
        {priPhase, priDir, priParErr, priInitErr, secMaster, priType} = 0;
        {secPhase, secDir, secParErr, secInitErr, secType} = 0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        ce = 1'b1;
        seed = 32'h51EC9F43;
        {badCount, compares, pCnt, sCnt, eCnt} = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        axiRd(`BPE_REG_CTRL, 34'h0);
        axiRd(`BPE_REG_STATUS, 34'h0);
        axiRd(`BPE_REG_MASK, 34'h0);
        axiRd(`BPE_REG_STATE, 34'h0);
        axiRd(8'h10, {`BPE_RESP_SLVERR, 32'h0});
        axiWr(8'h10, 32'hFFFFFFFF, `BPE_RESP_SLVERR);
        $display("test registers done");
        for (k = 0; k < 48; k = k + 1)
        begin
            r = $random(seed);
            runCase(k[0], k[5:4], k[2], k[1],
                (k[1] && !k[3]) ? 3'h7 : r[2:0], k[1] & k[3] & r[4],
                r[5], r[9:6]);
            $display("test case %0d done", k);
        end
        summarize;
    end
endmodule
